//--- pswc_pkg.sv
// Package for the pixel shift and window crop stage.
// Assumes a single 125 MHz pixel clock domain and an AHB-Lite register bus.
package pswc_pkg;

    // Register byte offsets
    localparam logic [7:0] PSWC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] PSWC_FIRSTCOL_OFS = 8'h04;
    localparam logic [7:0] PSWC_FIRSTLIN_OFS = 8'h08;
    localparam logic [7:0] PSWC_WIDTH_OFS    = 8'h0C;
    localparam logic [7:0] PSWC_HEIGHT_OFS   = 8'h10;
    localparam logic [7:0] PSWC_STATUS_OFS   = 8'h14;

    // Control field positions
    localparam int PSWC_CTRL_SHIFT_LSB = 0;
    localparam int PSWC_CTRL_SHIFT_W   = 3;
    localparam int PSWC_CTRL_WIDE_BIT  = 4;
    localparam int PSWC_CTRL_COLOR_BIT = 5;
    localparam int PSWC_CTRL_BIN_BIT   = 6;

    // Status field positions
    localparam int PSWC_STAT_ACTIVE_BIT = 0;
    localparam int PSWC_STAT_REJECT_BIT = 1;

    // Shift reset value and upper limit
    localparam logic [2:0] PSWC_SHIFT_RST = 3'h0;
    localparam logic [2:0] PSWC_SHIFT_MAX = 3'h4;

    // Sample and output widths
    localparam int PSWC_SAMPLE_W = 12;
    localparam int PSWC_NARROW_W = 8;

    // Bus constants
    localparam logic [1:0] PSWC_HTRANS_IDLE   = 2'b00;
    localparam logic [1:0] PSWC_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] PSWC_HSIZE_WORD    = 3'b010;

endpackage : pswc_pkg

//--- pswc_top.sv
// Pixel shift and window crop stage with AHB-Lite registers.
// Assumes sensor samples arrive synchronous to core_clk with frame and line starts.
//
// Function
// - 8-bit, no shift: output sample bits 11..4.
// - 8-bit, shift 1: output sample bits 10..3.
// - 8-bit, shift 2: output sample bits 9..2.
// - 8-bit, shift 3: output sample bits 8..1.
// - 8-bit, shift 4: output sample bits 7..0.
// - Any set bit above the field forces all output bits to one.
// - Shift value zero disables; one to four shift that many bits.
// - 12-bit, shift n: bits 11-n..0 then n zero bits.
// - Only pixels inside the window pass; others are dropped.
// - Coordinates count from top-left pixel, column zero line zero.
// - Offsets give first column and line; sizes give counts.
// - Monochrome: offsets and sizes accepted in steps of one.
// - Colour: offsets and sizes even, steps of two.
// - After reset the window is full sensor, offsets zero.
// - Offset changes accepted while capturing.
// - Size changes refused while capturing.
// - With binning, window counts binned columns and lines.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pswc_top
    import pswc_pkg::*;
#(
    parameter int SENSOR_COLS = 648,
    parameter int SENSOR_LINES = 488,
    parameter int COORD_W      = 12
)(
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // AHB-Lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    // Capture state from sequencing logic
    input  wire logic                     capturing,
    // Sample stream in
    input  wire logic                     inValid,
    input  wire logic                     inFrameStart,
    input  wire logic                     inLineStart,
    input  wire logic [PSWC_SAMPLE_W-1:0] inSample,
    // Pixel stream out
    output logic                          outValid,
    output logic                          outFrameStart,
    output logic                          outLineStart,
    output logic [PSWC_SAMPLE_W-1:0]      outPixel
);

    // Counters must hold the sensor size and fit a bus word
    if (COORD_W < $clog2(SENSOR_COLS + 1) || COORD_W < $clog2(SENSOR_LINES + 1) || COORD_W > 32)
    begin : gCoordChk
        $error("COORD_W does not suit sensor size or bus width");
    end

    localparam logic [COORD_W-1:0] COLS_MAX  = COORD_W'(SENSOR_COLS);
    localparam logic [COORD_W-1:0] LINES_MAX = COORD_W'(SENSOR_LINES);

    // Registers
    logic [2:0]         shiftSel_q;
    logic               wideFmt_q;
    logic               colorVar_q;
    logic               binning_q;
    logic [COORD_W-1:0] firstColReq_q;
    logic [COORD_W-1:0] firstLinReq_q;
    logic [COORD_W-1:0] firstCol_q;
    logic [COORD_W-1:0] firstLin_q;
    logic [COORD_W-1:0] winWidth_q;
    logic [COORD_W-1:0] winHeight_q;
    logic               rejected_q;

    // Bus address phase capture
    logic       wrPend_q;
    logic [7:0] addrPh_q;
    logic       takeReq;

    assign takeReq   = hsel && hready && htrans == PSWC_HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            addrPh_q <= 8'h00;
        end
        else if (hready)
        begin
            wrPend_q <= takeReq && hwrite;
            addrPh_q <= haddr[7:0];
        end
    end

    // Write checks
    logic [COORD_W-1:0] wrVal;
    logic               oddBad;
    logic               hiBad;
    logic               wrOk;

    assign wrVal  = hwdata[COORD_W-1:0];
    assign hiBad  = (hwdata >> COORD_W) != '0;
    assign oddBad = colorVar_q && wrVal[0];

    always_comb
    begin
        wrOk = 1'b0;
        unique case (addrPh_q)
            PSWC_FIRSTCOL_OFS:
                wrOk = !oddBad && ({1'b0, wrVal} + {1'b0, winWidth_q} <= {1'b0, COLS_MAX});
            PSWC_FIRSTLIN_OFS:
                wrOk = !oddBad && ({1'b0, wrVal} + {1'b0, winHeight_q} <= {1'b0, LINES_MAX});
            PSWC_WIDTH_OFS:
                wrOk = !oddBad && !capturing && wrVal != '0
                    && ({1'b0, wrVal} + {1'b0, firstColReq_q} <= {1'b0, COLS_MAX});
            PSWC_HEIGHT_OFS:
                wrOk = !oddBad && !capturing && wrVal != '0
                    && ({1'b0, wrVal} + {1'b0, firstLinReq_q} <= {1'b0, LINES_MAX});
            PSWC_CTRL_OFS:
                wrOk = hwdata[PSWC_CTRL_SHIFT_LSB +: PSWC_CTRL_SHIFT_W] <= PSWC_SHIFT_MAX;
            default:
                wrOk = 1'b0;
        endcase
        // Values wider than the counters never fit the sensor
        if (hiBad && addrPh_q != PSWC_CTRL_OFS)
            wrOk = 1'b0;
    end

    // Control register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            shiftSel_q <= PSWC_SHIFT_RST;
            wideFmt_q  <= 1'b0;
            colorVar_q <= 1'b0;
            binning_q  <= 1'b0;
        end
        else if (wrPend_q && wrOk && addrPh_q == PSWC_CTRL_OFS)
        begin
            shiftSel_q <= hwdata[PSWC_CTRL_SHIFT_LSB +: PSWC_CTRL_SHIFT_W];
            wideFmt_q  <= hwdata[PSWC_CTRL_WIDE_BIT];
            colorVar_q <= hwdata[PSWC_CTRL_COLOR_BIT];
            binning_q  <= hwdata[PSWC_CTRL_BIN_BIT];
        end
    end

    // Window registers, full sensor after reset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            firstColReq_q <= '0;
            firstLinReq_q <= '0;
            winWidth_q    <= COLS_MAX;
            winHeight_q   <= LINES_MAX;
            rejected_q    <= 1'b0;
        end
        else if (wrPend_q && (addrPh_q == PSWC_FIRSTCOL_OFS || addrPh_q == PSWC_FIRSTLIN_OFS
                 || addrPh_q == PSWC_WIDTH_OFS || addrPh_q == PSWC_HEIGHT_OFS))
        begin
            rejected_q <= !wrOk;
            if (wrOk && addrPh_q == PSWC_FIRSTCOL_OFS)
                firstColReq_q <= wrVal;
            if (wrOk && addrPh_q == PSWC_FIRSTLIN_OFS)
                firstLinReq_q <= wrVal;
            if (wrOk && addrPh_q == PSWC_WIDTH_OFS)
                winWidth_q <= wrVal;
            if (wrOk && addrPh_q == PSWC_HEIGHT_OFS)
                winHeight_q <= wrVal;
        end
    end

    // Offsets become live only at frame start
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            firstCol_q <= '0;
            firstLin_q <= '0;
        end
        else if (inValid && inFrameStart)
        begin
            firstCol_q <= firstColReq_q;
            firstLin_q <= firstLinReq_q;
        end
    end

    // Read data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (takeReq && !hwrite)
        begin
            unique case (haddr[7:0])
                PSWC_CTRL_OFS:
                    hrdata <= {25'h000_0000, binning_q, colorVar_q, wideFmt_q, 1'b0, shiftSel_q};
                PSWC_FIRSTCOL_OFS: hrdata <= 32'(firstColReq_q);
                PSWC_FIRSTLIN_OFS: hrdata <= 32'(firstLinReq_q);
                PSWC_WIDTH_OFS:    hrdata <= 32'(winWidth_q);
                PSWC_HEIGHT_OFS:   hrdata <= 32'(winHeight_q);
                PSWC_STATUS_OFS:   hrdata <= {30'h0000_0000, rejected_q, capturing};
                default:           hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Bit field select with saturation
    logic [PSWC_SAMPLE_W-1:0] shifted;
    logic                     overflow;
    logic [PSWC_SAMPLE_W-1:0] fieldOut;

    always_comb
    begin
        shifted  = inSample << shiftSel_q;
        overflow = (inSample >> (PSWC_SAMPLE_W - 32'(shiftSel_q))) != '0;
        if (shiftSel_q == 3'h0)
            overflow = 1'b0;
        if (overflow)
            fieldOut = '1;
        else if (wideFmt_q)
            fieldOut = shifted;
        else
            fieldOut = {4'h0, shifted[PSWC_SAMPLE_W-1 -: PSWC_NARROW_W]};
        if (overflow && !wideFmt_q)
            fieldOut = 12'h0FF;
    end

    // Position counters, origin top-left
    logic [COORD_W-1:0] col_q;
    logic [COORD_W-1:0] lin_q;
    logic [COORD_W-1:0] curCol;
    logic [COORD_W-1:0] curLin;

    always_comb
    begin
        curCol = inLineStart ? '0 : col_q;
        curLin = inFrameStart ? '0 : (inLineStart ? lin_q + 1'b1 : lin_q);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            col_q <= '0;
            lin_q <= '0;
        end
        else if (inValid)
        begin
            col_q <= curCol + 1'b1;
            lin_q <= curLin;
        end
    end

    // Window test; binned coordinates arrive already binned
    logic [COORD_W-1:0] useCol;
    logic [COORD_W-1:0] useLin;
    logic               inWin;

    always_comb
    begin
        useCol = (inFrameStart && inValid) ? firstColReq_q : firstCol_q;
        useLin = (inFrameStart && inValid) ? firstLinReq_q : firstLin_q;
        inWin  = curCol >= useCol && {1'b0, curCol} < {1'b0, useCol} + {1'b0, winWidth_q}
              && curLin >= useLin && {1'b0, curLin} < {1'b0, useLin} + {1'b0, winHeight_q};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            outValid      <= 1'b0;
            outFrameStart <= 1'b0;
            outLineStart  <= 1'b0;
            outPixel      <= '0;
        end
        else
        begin
            outValid      <= inValid && inWin;
            outFrameStart <= inValid && inWin && curCol == useCol && curLin == useLin;
            outLineStart  <= inValid && inWin && curCol == useCol;
            outPixel      <= inValid && inWin ? fieldOut : outPixel;
        end
    end

    // Assertions
    drop_outside_a : assert property (@(posedge core_clk) disable iff (rst)
        (inValid && !inWin) |=> !outValid)
        else $error("pixel outside window forwarded");

    pass_inside_a : assert property (@(posedge core_clk) disable iff (rst)
        (inValid && inWin) |=> outValid && outPixel == $past(fieldOut))
        else $error("pixel inside window lost");

    narrow_field_a : assert property (@(posedge core_clk) disable iff (rst)
        (!wideFmt_q && !overflow) |-> fieldOut == {4'h0, 8'(inSample >> (3'h4 - shiftSel_q))})
        else $error("narrow field select wrong");

    saturate_a : assert property (@(posedge core_clk) disable iff (rst)
        (shiftSel_q != 3'h0 && inSample[11]) |-> (wideFmt_q ? fieldOut == 12'hFFF : fieldOut == 12'h0FF))
        else $error("saturation missing");

    narrow_upper_a : assert property (@(posedge core_clk) disable iff (rst)
        (outValid && $past(!wideFmt_q)) |-> outPixel[11:8] == 4'h0)
        else $error("narrow pixel has upper bits set");

    wide_field_a : assert property (@(posedge core_clk) disable iff (rst)
        (wideFmt_q && !overflow) |-> fieldOut == (inSample << shiftSel_q))
        else $error("wide field wrong");

    size_frozen_a : assert property (@(posedge core_clk) disable iff (rst)
        (capturing && $past(capturing)) |-> $stable(winWidth_q) && $stable(winHeight_q))
        else $error("size changed while capturing");

    offset_frame_a : assert property (@(posedge core_clk) disable iff (rst)
        !$past(inValid && inFrameStart) |-> $stable(firstCol_q) && $stable(firstLin_q))
        else $error("offset changed mid-frame");

    bounds_held_a : assert property (@(posedge core_clk) disable iff (rst)
        ({1'b0, firstColReq_q} + {1'b0, winWidth_q} <= {1'b0, COLS_MAX})
        && ({1'b0, firstLinReq_q} + {1'b0, winHeight_q} <= {1'b0, LINES_MAX}))
        else $error("window exceeds sensor");

    shift_range_a : assert property (@(posedge core_clk) disable iff (rst)
        shiftSel_q <= PSWC_SHIFT_MAX)
        else $error("shift out of range");

endmodule : pswc_top

`default_nettype wire

//--- pswc_sink.sv
// Partner model: the image transmit path that takes forwarded pixels.
// Assumes pixels are qualified by outValid at rising edges of core_clk.
`timescale 1ns/1ps
`default_nettype none

module pswc_sink (
    // Clock
    input  wire logic        core_clk,
    // Forwarded pixel stream
    input  wire logic        outValid,
    input  wire logic        outFrameStart,
    input  wire logic        outLineStart,
    input  wire logic [11:0] outPixel
);
    logic [13:0] rxQ[$];

    // Never stalls, so every forwarded pixel is kept
    always @(posedge core_clk)
        if (outValid)
            rxQ.push_back({outFrameStart, outLineStart, outPixel});
endmodule : pswc_sink

`default_nettype wire

//--- pswc_top_tb.sv
// Testbench for the pixel shift and window crop stage.
// Assumes the design package, the design top and the pixel sink model.
`timescale 1ns/1ps
`default_nettype none

module pswc_top_tb
    import pswc_pkg::*;
;
    localparam int COLS  = 16;
    localparam int LINES = 8;

    logic        core_clk     = 1'b0;
    logic        rst          = 1'b1;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = '0;
    logic [1:0]  htrans       = PSWC_HTRANS_IDLE;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = PSWC_HSIZE_WORD;
    logic [31:0] hwdata       = '0;
    logic        capturing    = 1'b0;
    logic        inValid      = 1'b0;
    logic        inFrameStart = 1'b0;
    logic        inLineStart  = 1'b0;
    logic [11:0] inSample     = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        outValid;
    logic        outFrameStart;
    logic        outLineStart;
    logic [11:0] outPixel;
    wire logic   hready       = hreadyout;
    int          err_count    = 0;
    int          total_checks = 0;
    logic [13:0] expQ[$];

    pswc_top #(.SENSOR_COLS(COLS), .SENSOR_LINES(LINES)) uut (
        .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .capturing, .inValid, .inFrameStart,
        .inLineStart, .inSample, .outValid, .outFrameStart, .outLineStart, .outPixel
    );

    pswc_sink far (.core_clk, .outValid, .outFrameStart, .outLineStart, .outPixel);

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1)
        begin
            err_count++;
            results();
        end
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= PSWC_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        htrans <= PSWC_HTRANS_IDLE;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        check(what, r, exp);
    endtask : rdc

    function automatic logic [11:0] conv(input logic [11:0] s, input int sh, input logic wide);
        if ((s >> (12 - sh)) != 0)
            return wide ? 12'hFFF : 12'h0FF;
        return wide ? 12'(s << sh) : 12'((s >> (4 - sh)) & 12'h0FF);
    endfunction : conv

    // One whole sensor frame, back to back; expected pixels queued alongside
    task automatic frame(input int fc, input int fl, input int w, input int h,
                         input int sh, input logic wide, input int mx = 4096);
        logic [11:0] s;
        for (int l = 0; l < LINES; l++)
            for (int c = 0; c < COLS; c++)
            begin
                s = 12'((c * 251 + l * 37 + sh * 7) % mx);
                inValid      <= 1'b1;
                inFrameStart <= (c == 0 && l == 0);
                inLineStart  <= (c == 0);
                inSample     <= s;
                if (c >= fc && c < fc + w && l >= fl && l < fl + h)
                    expQ.push_back({c == fc && l == fl, c == fc, conv(s, sh, wide)});
                @(posedge core_clk);
            end
        inValid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : frame

    task automatic cmp_frame();
        check("pixel count", 32'(far.rxQ.size()), 32'(expQ.size()));
        foreach (expQ[i])
            if (i < far.rxQ.size())
                check("pixel", 32'(far.rxQ[i]), 32'(expQ[i]));
        expQ.delete();
        far.rxQ.delete();
    endtask : cmp_frame

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdc(PSWC_CTRL_OFS, 32'h0000_0000, "ctrl");
        rdc(PSWC_FIRSTCOL_OFS, 32'h0000_0000, "first column");
        rdc(PSWC_FIRSTLIN_OFS, 32'h0000_0000, "first line");
        rdc(PSWC_WIDTH_OFS, 32'(COLS), "width");
        rdc(PSWC_HEIGHT_OFS, 32'(LINES), "height");
        rdc(PSWC_STATUS_OFS, 32'h0000_0000, "status");
        rdc(8'h18, 32'h0000_0000, "unmapped");
        check("hresp", 32'(hresp), 32'h0000_0000);
        // Colour variant: odd window values refused
        wr(PSWC_CTRL_OFS, 32'h0000_0020);
        wr(PSWC_WIDTH_OFS, 32'h0000_000E);
        wr(PSWC_FIRSTCOL_OFS, 32'h0000_0001);
        rdc(PSWC_FIRSTCOL_OFS, 32'h0000_0000, "odd column");
        wr(PSWC_FIRSTCOL_OFS, 32'h0000_0002);
        rdc(PSWC_FIRSTCOL_OFS, 32'h0000_0002, "even column");
        wr(PSWC_FIRSTCOL_OFS, 32'h0000_0000);
        wr(PSWC_WIDTH_OFS, 32'(COLS));
        wr(PSWC_CTRL_OFS, 32'h0000_0000);
        frame(0, 0, COLS, LINES, 0, 1'b0);
        cmp_frame();
        // Window kept inside the sensor by the write checks; writes past the edge are refused
        wr(PSWC_WIDTH_OFS, 32'h0000_0005);
        wr(PSWC_HEIGHT_OFS, 32'h0000_0004);
        wr(PSWC_FIRSTCOL_OFS, 32'h0000_0003);
        wr(PSWC_FIRSTLIN_OFS, 32'h0000_0002);
        rdc(PSWC_FIRSTCOL_OFS, 32'h0000_0003, "odd mono column");
        wr(PSWC_CTRL_OFS, 32'h0000_0005);
        rdc(PSWC_CTRL_OFS, 32'h0000_0000, "shift above four");
        wr(PSWC_CTRL_OFS, 32'h0000_0053);
        rdc(PSWC_CTRL_OFS, 32'h0000_0053, "binning and format");
        for (int wide = 0; wide < 2; wide++)
            for (int sh = 0; sh < 5; sh++)
            begin
                wr(PSWC_CTRL_OFS, 32'(sh + wide * 16));
                frame(3, 2, 5, 4, sh, 1'(wide));
                cmp_frame();
                // Brightest samples kept below the safe limit for this shift
                frame(3, 2, 5, 4, sh, 1'(wide), 4096 >> sh);
                cmp_frame();
            end
        wr(PSWC_WIDTH_OFS, 32'h0000_000E);
        rdc(PSWC_WIDTH_OFS, 32'h0000_0005, "oversize width");
        wr(PSWC_WIDTH_OFS, 32'h0000_1004);
        rdc(PSWC_WIDTH_OFS, 32'h0000_0005, "width above counter range");
        rdc(PSWC_STATUS_OFS, 32'h0000_0002, "reject flag");
        capturing <= 1'b1;
        wr(PSWC_WIDTH_OFS, 32'h0000_0004);
        rdc(PSWC_WIDTH_OFS, 32'h0000_0005, "width in capture");
        // Offset moved mid-frame: this frame keeps the old position
        fork
            frame(3, 2, 5, 4, 4, 1'b1);
            begin
                repeat (40) @(posedge core_clk);
                wr(PSWC_FIRSTCOL_OFS, 32'h0000_0002);
            end
        join
        cmp_frame();
        frame(2, 2, 5, 4, 4, 1'b1);
        cmp_frame();
        capturing <= 1'b0;
        wr(PSWC_WIDTH_OFS, 32'h0000_0004);
        rdc(PSWC_WIDTH_OFS, 32'h0000_0004, "width when idle");
        results();
    end
endmodule : pswc_top_tb

`default_nettype wire
